// *** hdl/atp_pkg.sv ***
package atp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses (printed offsets, each times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CTRL_STATUS = 8'h34;  // printed 0D
  localparam logic [7:0] ADDR_COUNT_HIGH        = 8'h38;  // printed 0E
  localparam logic [7:0] ADDR_COUNT_LOW         = 8'h3C;  // printed 0F
  localparam logic [7:0] ADDR_RELOAD_HIGH       = 8'h40;  // printed 10
  localparam logic [7:0] ADDR_RELOAD_LOW        = 8'h44;  // printed 11
  localparam logic [7:0] ADDR_OUTPUT_CONTROL    = 8'h48;  // printed 12
  localparam logic [7:0] ADDR_WAVEFORM_STATUS   = 8'h4C;  // printed 13
  localparam logic [7:0] ADDR_DUTY_HIGH         = 8'h5C;  // printed 17
  localparam logic [7:0] ADDR_DUTY_LOW          = 8'h60;  // printed 18

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CMP_IRQ_EN  = 0;
  localparam int BIT_OVF_IRQ_EN  = 1;
  localparam int BIT_OVF_FLAG    = 2;
  localparam int BIT_CLK_SEL_LO  = 3;
  localparam int BIT_CLK_SEL_HI  = 4;
  localparam int BIT_POLARITY    = 1;
  localparam int BIT_CMP_FLAG    = 0;
  localparam int BIT_OUT_ENABLE  = 0;

  // ----------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------
  localparam int          CNT_W         = 12;
  localparam logic [11:0] CNT_MAX       = 12'hFFF;
  localparam logic [11:0] CNT_RESET     = 12'h000;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          SLOW_DIVIDE   = 32;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          TIMEBASE_US   = 1000;
  localparam int          TIMEBASE_CYC  = CLK_HZ / 1_000_000 * TIMEBASE_US;

  // Clock select codes
  localparam logic [1:0] CLK_SEL_OFF      = 2'h0;
  localparam logic [1:0] CLK_SEL_TIMEBASE = 2'h1;
  localparam logic [1:0] CLK_SEL_CPU      = 2'h2;

  // Power mode inputs grouped
  typedef struct packed {
    logic slow;
    logic wait_mode;
    logic halt;
    logic active_halt;
  } atp_power_type;

  // Interrupt request pair
  typedef struct packed {
    logic overflow;
    logic compare;
  } atp_irq_type;

endpackage : atp_pkg

// *** hdl/atp_divider.sv ***
`timescale 1ns/1ps
// Divider gated by run_in, producing a one-cycle enable every DIVIDE cycles that run_in is high
module atp_divider #(
  parameter int DIVIDE = 32
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // Control
  input  wire logic run_in,
  // Enable pulse
  output logic      tick_out
);

  localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

  logic [W-1:0] count_reg;
  wire          at_last = (count_reg == LAST);

  // Count and wrap while running
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      count_reg <= '0;
    end else if (run_in) begin
      count_reg <= at_last ? '0 : count_reg + W'(1);
    end
  end

  assign tick_out = run_in && at_last;

endmodule : atp_divider

// *** hdl/atp_compare.sv ***
`timescale 1ns/1ps
// Compare source selection and match detection
module atp_compare (
  // Values
  input  wire logic [11:0] count_in,
  input  wire logic [11:0] duty_in,
  input  wire logic [11:0] shadow_in,
  // Control
  input  wire logic        pwm_mode_in,
  input  wire logic        armed_in,
  input  wire logic        tick_in,
  // Result
  output logic             match_out
);

  // Shadow in PWM mode, direct duty otherwise
  wire [11:0] target = pwm_mode_in ? shadow_in : duty_in;

  // Locked while low byte pending, zero never matches
  assign match_out = tick_in && armed_in && (duty_in != 12'h000)
                     && (count_in == target);

endmodule : atp_compare

// *** hdl/atp_timer.sv ***
`timescale 1ns/1ps
// What this block does
// - Output enable routes the waveform to the pin as push-pull; clear blocks it.
// - Period is counter clock times 4096 minus reload value.
// - Counter starts from zero after reset once a clock is selected.
// - Overflow loads reload, copies duty into shadow, drives waveform high unless duty equals reload.
// - In PWM mode waveform goes low when counter equals active duty.
// - Polarity bit inverts the waveform at the pin.
// - Duty high write locks compare until the low byte is written.
// - Compare mode uses duty directly, PWM mode uses the shadow.
// - In compare mode a written duty takes effect at once.
// - Counter reaching duty sets compare flag; irq only when enabled.
// - Zero duty never produces compare events.
// - Every overflow copies duty to shadow even with low byte pending.
// - Slow divides counter clock by 32; wait no effect; halt stops.
// - Active-halt stops timer unless timebase clock and overflow irq enabled.
// - Overflow and compare drive separate requests, flag and enable both set.
// - Clock select 00 off, 01 timebase, 10 CPU, 11 reserved; reset clears.
// - Wrap from maximum sets overflow flag; status read clears it.
// - Reading waveform status register clears the compare flag.
// - Output enable clear releases the pin for general purpose use.
module atp_timer #(
  parameter int TIMEBASE_CYCLES = atp_pkg::TIMEBASE_CYC
) (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Power modes
  input  wire atp_pkg::atp_power_type power_in,
  // Pin and requests
  output logic                       waveform_output_out,
  output logic                       waveform_output_oe_out,
  output atp_pkg::atp_irq_type       irq_out,
  output logic                       wake_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [11:0] upcounter_value_reg;
  logic [11:0] reload_value_reg;
  logic [11:0] duty_value_reg;
  logic [11:0] shadow_reg;
  logic        armed_reg;
  logic [1:0]  clock_select_reg;
  logic        overflow_flag_reg;
  logic        overflow_irq_enable_reg;
  logic        compare_irq_enable_reg;
  logic        compare_match_flag_reg;
  logic        output_polarity_reg;
  logic        pwm_output_enable_reg;
  logic        wave_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access    = psel_in && penable_in;
  wire wr        = access && pwrite_in;
  wire rd        = access && !pwrite_in;
  wire [7:0] wb  = pwdata_in[7:0];
  wire hit_ctrl  = (paddr_in == atp_pkg::ADDR_TIMER_CTRL_STATUS);
  wire hit_cnth  = (paddr_in == atp_pkg::ADDR_COUNT_HIGH);
  wire hit_cntl  = (paddr_in == atp_pkg::ADDR_COUNT_LOW);
  wire hit_relh  = (paddr_in == atp_pkg::ADDR_RELOAD_HIGH);
  wire hit_rell  = (paddr_in == atp_pkg::ADDR_RELOAD_LOW);
  wire hit_outc  = (paddr_in == atp_pkg::ADDR_OUTPUT_CONTROL);
  wire hit_wsts  = (paddr_in == atp_pkg::ADDR_WAVEFORM_STATUS);
  wire hit_dutyh = (paddr_in == atp_pkg::ADDR_DUTY_HIGH);
  wire hit_dutyl = (paddr_in == atp_pkg::ADDR_DUTY_LOW);
  wire mapped    = hit_ctrl | hit_cnth | hit_cntl | hit_relh | hit_rell
                   | hit_outc | hit_wsts | hit_dutyh | hit_dutyl;

  // Read mux, reserved bits zero
  wire [7:0] rmux =
      hit_ctrl  ? {3'h0, clock_select_reg, overflow_flag_reg,
                   overflow_irq_enable_reg, compare_irq_enable_reg} :
      hit_cnth  ? {4'h0, upcounter_value_reg[11:8]} :
      hit_cntl  ? upcounter_value_reg[7:0] :
      hit_relh  ? {4'h0, reload_value_reg[11:8]} :
      hit_rell  ? reload_value_reg[7:0] :
      hit_outc  ? {7'h00, pwm_output_enable_reg} :
      hit_wsts  ? {6'h00, output_polarity_reg, compare_match_flag_reg} :
      hit_dutyh ? {4'h0, duty_value_reg[11:8]} :
      hit_dutyl ? duty_value_reg[7:0] : 8'h00;

  assign pready_out  = 1'b1;
  assign pslverr_out = access && !mapped;
  assign prdata_out  = rdata_reg;

  // ----------------------------------------------------------------
  // Counter clock generation
  // ----------------------------------------------------------------
  logic tb_tick;
  logic slow_tick;
  logic cnt_tick;

  // Companion timebase, counts unless halted
  atp_divider #(.DIVIDE(TIMEBASE_CYCLES)) u_timebase (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (!power_in.halt),
    .tick_out   (tb_tick)
  );

  wire sel_tb  = (clock_select_reg == atp_pkg::CLK_SEL_TIMEBASE);
  wire sel_cpu = (clock_select_reg == atp_pkg::CLK_SEL_CPU);
  wire raw_tick = (sel_tb && tb_tick) || sel_cpu;

  // Halt stops, active-halt keeps only timebase with overflow irq
  wire ah_keep  = sel_tb && overflow_irq_enable_reg;
  wire running  = !power_in.halt && (!power_in.active_halt || ah_keep);

  // Slow mode divides the selected clock by 32
  atp_divider #(.DIVIDE(atp_pkg::SLOW_DIVIDE)) u_slow (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .run_in     (raw_tick && running && power_in.slow),
    .tick_out   (slow_tick)
  );

  assign cnt_tick = running && (power_in.slow ? slow_tick : raw_tick);

  // ----------------------------------------------------------------
  // Counter, overflow and compare
  // ----------------------------------------------------------------
  wire wrap = cnt_tick && (upcounter_value_reg == atp_pkg::CNT_MAX);
  logic match;

  atp_compare u_compare (
    .count_in    (upcounter_value_reg),
    .duty_in     (duty_value_reg),
    .shadow_in   (shadow_reg),
    .pwm_mode_in (pwm_output_enable_reg),
    .armed_in    (armed_reg),
    .tick_in     (cnt_tick),
    .match_out   (match)
  );

  wire [11:0] cnt_next = wrap ? reload_value_reg
                              : upcounter_value_reg + 12'h001;

  // Counter from zero at reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      upcounter_value_reg <= atp_pkg::CNT_RESET;
    end else if (cnt_tick) begin
      upcounter_value_reg <= cnt_next;
    end
  end

  // Shadow copied at every overflow, pending or not
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      shadow_reg <= atp_pkg::CNT_RESET;
    end else if (wrap) begin
      shadow_reg <= duty_value_reg;
    end
  end

  // Look-ahead on the next count, so the pin is already low while the count equals duty
  // Shadow takes the duty value at the wrap, so the wrap compares against duty
  wire [11:0] wave_target = wrap ? duty_value_reg : shadow_reg;
  wire        wave_low    = cnt_tick && armed_reg && pwm_output_enable_reg
                            && (cnt_next == wave_target);

  // Waveform: high at overflow unless reload equals the active duty, low once the count reaches the active duty
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wave_reg <= 1'b0;
    end else if (wave_low) begin
      wave_reg <= 1'b0;
    end else if (wrap) begin
      wave_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      clock_select_reg        <= 2'h0;
      overflow_irq_enable_reg <= 1'b0;
      compare_irq_enable_reg  <= 1'b0;
      reload_value_reg        <= atp_pkg::CNT_RESET;
      duty_value_reg          <= atp_pkg::CNT_RESET;
      armed_reg               <= 1'b1;
      output_polarity_reg     <= 1'b0;
      pwm_output_enable_reg   <= 1'b0;
    end else if (wr) begin
      if (hit_ctrl) begin
        clock_select_reg        <= wb[atp_pkg::BIT_CLK_SEL_HI:atp_pkg::BIT_CLK_SEL_LO];
        overflow_irq_enable_reg <= wb[atp_pkg::BIT_OVF_IRQ_EN];
        compare_irq_enable_reg  <= wb[atp_pkg::BIT_CMP_IRQ_EN];
      end
      if (hit_relh) reload_value_reg[11:8] <= wb[3:0];
      if (hit_rell) reload_value_reg[7:0]  <= wb;
      if (hit_dutyh) begin
        duty_value_reg[11:8] <= wb[3:0];
        armed_reg            <= 1'b0;
      end
      if (hit_dutyl) begin
        duty_value_reg[7:0] <= wb;
        armed_reg           <= 1'b1;
      end
      if (hit_wsts) output_polarity_reg   <= wb[atp_pkg::BIT_POLARITY];
      if (hit_outc) pwm_output_enable_reg <= wb[atp_pkg::BIT_OUT_ENABLE];
    end
  end

  // Read clears only a flag that the read actually reported
  wire setup_rd = psel_in && !penable_in && !pwrite_in;
  wire ovf_seen = rd && hit_ctrl && rdata_reg[atp_pkg::BIT_OVF_FLAG];
  wire cmp_seen = rd && hit_wsts && rdata_reg[atp_pkg::BIT_CMP_FLAG];

  // Flags: hardware set wins over read clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      overflow_flag_reg      <= 1'b0;
      compare_match_flag_reg <= 1'b0;
    end else begin
      overflow_flag_reg      <= wrap | (overflow_flag_reg & !ovf_seen);
      compare_match_flag_reg <= match | (compare_match_flag_reg & !cmp_seen);
    end
  end

  // Read data loaded in the setup cycle, so it stands through the access phase
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup_rd) begin
      rdata_reg <= {24'h00_0000, rmux};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waveform_output_out    = pwm_output_enable_reg &&
                                  (wave_reg ^ output_polarity_reg);
  assign waveform_output_oe_out = pwm_output_enable_reg;
  assign irq_out.overflow = overflow_flag_reg && overflow_irq_enable_reg;
  assign irq_out.compare  = compare_match_flag_reg && compare_irq_enable_reg;
  assign wake_out = (power_in.wait_mode && (irq_out.overflow || irq_out.compare))
                    || (power_in.active_halt && ah_keep && irq_out.overflow);

endmodule : atp_timer

// *** testbench/atp_timer_monitor.sv ***
`timescale 1ns/1ps
module atp_timer_monitor #(
  parameter int TIMEBASE_CYCLES = 10
) (
  // Clock, reset and bus
  input wire logic                   ref_clk_in,
  input wire logic                   rst_b_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pwrite_in,
  input wire logic [7:0]             paddr_in,
  input wire logic [31:0]            pwdata_in,
  input wire logic [31:0]            prdata_out,
  input wire logic                   pready_out,
  input wire logic                   pslverr_out,
  // Power, pin and requests
  input wire atp_pkg::atp_power_type power_in,
  input wire logic                   waveform_output_out,
  input wire logic                   waveform_output_oe_out,
  input wire atp_pkg::atp_irq_type   irq_out,
  input wire logic                   wake_out
);
  // ------------------------------
  // Control bits as last written
  // ------------------------------
  logic [7:0] ctrl_reg;
  logic       oe_reg;
  wire        acc    = psel_in & penable_in & pready_out;
  wire        mapped = paddr_in inside {8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h5C, 8'h60};
  // Follow writes to control and enable
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= 8'h00;
      oe_reg   <= 1'b0;
    end else if (acc && pwrite_in && paddr_in == atp_pkg::ADDR_TIMER_CTRL_STATUS) begin
      ctrl_reg <= pwdata_in[7:0];
    end else if (acc && pwrite_in && paddr_in == atp_pkg::ADDR_OUTPUT_CONTROL) begin
      oe_reg <= pwdata_in[0];
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_OE_TRACK: assert property (waveform_output_oe_out == oe_reg)
    else $error("pin enable differs from written bit");
  AST_PIN_RELEASED: assert property (!waveform_output_oe_out |-> !waveform_output_out)
    else $error("pin driven while released");
  AST_OVF_MASK: assert property (irq_out.overflow |-> ctrl_reg[1])
    else $error("overflow request while masked");
  AST_CMP_MASK: assert property (irq_out.compare |-> ctrl_reg[0])
    else $error("compare request while masked");
  AST_CLK_OFF: assert property ((ctrl_reg[4:3] == 2'h0 && $stable(ctrl_reg))[*3] |-> !$rose(irq_out.overflow))
    else $error("overflow with counter clock off");
  AST_HALT_STOP: assert property ((power_in.halt && $stable(ctrl_reg))[*3] |-> !$rose(irq_out.overflow))
    else $error("overflow during halt");
  AST_WAKE_WAIT: assert property (power_in.wait_mode && (irq_out.overflow || irq_out.compare) |-> ##[0:1] wake_out)
    else $error("no wake from wait");
  AST_NO_WAKE_HALT: assert property ((power_in.halt && !power_in.wait_mode && !power_in.active_halt)[*2] |-> !wake_out)
    else $error("wake from halt");
  AST_AHALT_WAKE: assert property ((power_in.active_halt && !power_in.wait_mode)[*2] ##0 wake_out |-> ctrl_reg[4:3] == 2'h1 && ctrl_reg[1])
    else $error("active halt wake without timebase and enable");
  AST_SLVERR: assert property (psel_in && penable_in |-> pslverr_out == !mapped)
    else $error("error response wrong for address");
  AST_UNMAPPED_ZERO: assert property (acc && !pwrite_in && !mapped |-> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : atp_timer_monitor

bind atp_timer atp_timer_monitor #(.TIMEBASE_CYCLES(TIMEBASE_CYCLES)) u_mon (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .power_in(power_in),
  .waveform_output_out(waveform_output_out), .waveform_output_oe_out(waveform_output_oe_out),
  .irq_out(irq_out), .wake_out(wake_out));

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ------------------------------
  // Signals and register rows
  // ------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] x; logic err;} atp_row_type;
  logic                   ref_clk_in = 1'b0;
  logic                   rst_b_in   = 1'b0;
  logic                   psel_in    = 1'b0;
  logic                   penable_in = 1'b0;
  logic                   pwrite_in  = 1'b0;
  logic [7:0]             paddr_in   = 8'h00;
  logic [31:0]            pwdata_in  = 32'h0000_0000;
  logic [31:0]            prdata_out;
  logic                   pready_out, pslverr_out, pin, pin_oe, wake_out;
  atp_pkg::atp_power_type power_in   = 4'h0;
  atp_pkg::atp_irq_type   irq_out;
  int                     n_errors = 0;
  int                     samples_checked = 0;
  int                     k;
  int                     n_hi;
  logic [31:0]            q;
  logic                   e;
  atp_row_type            rows [10] = '{
    '{8'h34, 8'h1F, 8'h1B, 1'b0}, '{8'h38, 8'hFF, 8'h00, 1'b0}, '{8'h3C, 8'hFF, 8'h00, 1'b0},
    '{8'h40, 8'hFF, 8'h0F, 1'b0}, '{8'h44, 8'hA5, 8'hA5, 1'b0}, '{8'h48, 8'hFF, 8'h01, 1'b0},
    '{8'h4C, 8'hFF, 8'h02, 1'b0}, '{8'h5C, 8'hFF, 8'h0F, 1'b0}, '{8'h60, 8'h3C, 8'h3C, 1'b0},
    '{8'h70, 8'hFF, 8'h00, 1'b1}};
  // 25 MHz clock
  always #20 ref_clk_in = ~ref_clk_in;
  atp_timer #(.TIMEBASE_CYCLES(10)) DUT (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .power_in(power_in),
    .waveform_output_out(pin), .waveform_output_oe_out(pin_oe), .irq_out(irq_out), .wake_out(wake_out));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Bounded wait ran out
  task automatic expire(input int lim);
    if (k >= lim) begin
      n_errors++;
      stop_test();
    end
  endtask : expire
  task automatic do_reset;
    rst_b_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
  endtask : do_reset
  // One bus transfer, read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= {24'h00_0000, d};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    expire(50);
    e = pslverr_out;
    q = prdata_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb
  // Cycles the pin stays high over two counter periods
  task automatic count_high(output int n);
    n = 0;
    repeat (32) begin
      @(posedge ref_clk_in);
      if (pin === 1'b1) n++;
    end
  endtask : count_high
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    check("read data", q, {24'h00_0000, x});
  endtask : rd
  task automatic wait_irq(input logic cmp, input int lim);
    for (k = 0; k < lim && (cmp ? irq_out.compare : irq_out.overflow) !== 1'b1; k++) begin
      @(posedge ref_clk_in);
    end
    expire(lim);
  endtask : wait_irq
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (pin !== v && n < 9000) begin
      @(posedge ref_clk_in);
      n++;
    end
    k = n;
    expire(9000);
  endtask : wait_lvl
  // Measure one full waveform cycle from a rising edge
  task automatic pwm_case(input logic [7:0] c, input logic p, input logic s, input int hi, input int per);
    int h;
    int l;
    wr(8'h34, c);
    wr(8'h4C, {6'h00, p, 1'b0});
    power_in.slow <= s;
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, h);
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, l);
    check("high time", h, hi);
    check("period", h + l, per);
    $display("waveform case %h done", c);
  endtask : pwm_case
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rd(rows[i].a, 8'h00);
      wr(rows[i].a, rows[i].d);
      check("error", {31'h0000_0000, e}, {31'h0000_0000, rows[i].err});
      rd(rows[i].a, rows[i].x);
    end
    $display("registers done");
    do_reset();
    wr(8'h40, 8'h0F);
    wr(8'h44, 8'hF0);
    wr(8'h5C, 8'h0F);
    wr(8'h60, 8'hF4);
    wr(8'h48, 8'h01);
    check("pin enable", {31'h0000_0000, pin_oe}, 32'h0000_0001);
    pwm_case(8'h10, 1'b0, 1'b0, 4, 16);
    pwm_case(8'h10, 1'b1, 1'b0, 12, 16);
    pwm_case(8'h10, 1'b0, 1'b1, 128, 512);
    pwm_case(8'h08, 1'b0, 1'b0, 40, 160);
    wr(8'h5C, 8'h0F);
    wr(8'h60, 8'hF0);
    wr(8'h34, 8'h10);
    repeat (40) @(posedge ref_clk_in);
    count_high(n_hi);
    check("flat low", n_hi, 0);
    wr(8'h4C, 8'h02);
    count_high(n_hi);
    check("flat high", n_hi, 32);
    wr(8'h4C, 8'h00);
    $display("duty equal reload done");
    wr(8'h34, 8'h12);
    wait_irq(1'b0, 40);
    power_in <= 4'h4;
    repeat (2) @(posedge ref_clk_in);
    check("wake in wait", {31'h0000_0000, wake_out}, 32'h0000_0001);
    power_in <= 4'h2;
    rd(8'h34, 8'h16);
    repeat (100) @(posedge ref_clk_in);
    rd(8'h34, 8'h12);
    check("wake in halt", {31'h0000_0000, wake_out}, 32'h0000_0000);
    power_in <= 4'h1;
    wr(8'h34, 8'h0A);
    wait_irq(1'b0, 400);
    repeat (2) @(posedge ref_clk_in);
    check("wake in active halt", {31'h0000_0000, wake_out}, 32'h0000_0001);
    power_in <= 4'h0;
    wr(8'h34, 8'h02);
    rd(8'h34, 8'h06);
    rd(8'h34, 8'h02);
    $display("power modes done");
    wr(8'h48, 8'h00);
    apb(1'b0, 8'h4C, 8'h00);
    wr(8'h5C, 8'h0F);
    wr(8'h34, 8'h11);
    repeat (40) @(posedge ref_clk_in);
    check("locked compare", {31'h0000_0000, irq_out.compare}, 32'h0000_0000);
    wr(8'h60, 8'hF4);
    wait_irq(1'b1, 20);
    wr(8'h34, 8'h01);
    rd(8'h4C, 8'h01);
    rd(8'h4C, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h44, 8'h00);
    wr(8'h5C, 8'h00);
    wr(8'h60, 8'h00);
    wr(8'h34, 8'h11);
    repeat (4200) @(posedge ref_clk_in);
    check("zero duty compare", {31'h0000_0000, irq_out.compare}, 32'h0000_0000);
    $display("compare done");
    stop_test();
  end
endmodule : tb_top
